// ### hw/scw_pkg.sv
// Package of constants and carrier types for the scan cycle watchdog.
package scw_pkg;

	// Timeout setting limits and default, in milliseconds.
	localparam int unsigned TIMEOUT_MIN_MS = 100;
	localparam int unsigned TIMEOUT_MAX_MS = 5000;
	localparam logic [12:0] TIMEOUT_DEFAULT_MS = 13'h0190;

	// Core clock rate and the cycles that make one millisecond tick.
	localparam int unsigned CORE_CLK_HZ = 40000000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned TICK_CYCLES = CORE_CLK_HZ / MS_PER_S;

	// Reset values of the time words.
	localparam logic [15:0] TIME_WORD_RESET = 16'h0000;

	// One less than the length of the system reset pulse after a watchdog error, in cycles.
	localparam int unsigned SYS_RESET_CYCLES = 16;

	// Program language of the running program.
	typedef enum logic [0:0] {
		SCW_LANG_LADDER = 1'b0,
		SCW_LANG_FBD = 1'b1
	} scw_lang_type;

	// Watchdog state.
	typedef enum logic [1:0] {
		SCW_ST_STOPPED = 2'b00,
		SCW_ST_RUNNING = 2'b01,
		SCW_ST_TRIPPED = 2'b10
	} scw_state_type;

	// Program-side events that steer the watchdog.
	typedef struct packed {
		logic running;
		scw_lang_type lang;
		logic scan_start;
		logic idle_instruction;
	} scw_prog_type;

	// Readable time words, in milliseconds.
	typedef struct packed {
		logic [15:0] max_scan_time_word;
		logic [15:0] exec_time_word;
	} scw_times_type;

endpackage : scw_pkg

// ### hw/scw_tick.sv
// Millisecond tick generator for the scan cycle watchdog.
`timescale 1ns/1ps
module scw_tick import scw_pkg::*; #(
	parameter int unsigned CYCLES = TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic clear,
	output logic tick
);
	localparam int W = $clog2(CYCLES);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	initial begin
		if (CYCLES < 2) $error("scw_tick needs at least two cycles per tick.");
	end

	// Counts cycles; clear restarts the millisecond so timing starts from a scan edge.
	always_comb begin
		if (clear || count_reg == LAST) begin
			count_next = '0;
		end else begin
			count_next = count_reg + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	// Pulses for one cycle at the end of each full millisecond.
	assign tick = !clear && (count_reg == LAST);

endmodule : scw_tick

// ### hw/scw_watchdog.sv
// Scan cycle watchdog: times each scan and resets the system on overrun.
// Behaviour
// - While the program runs, a scan that lasts longer than the set timeout raises a watchdog error.
// - A watchdog error resets the whole system so it can return to normal operation.
// - Each idle instruction executed by a ladder program restarts the watchdog timing.
// - A function block diagram program restarts the watchdog timing only at a scan start.
// - The timeout accepts 100 ms to 5000 ms and defaults to 400 ms when none is given.
// - The longest scan time seen so far is kept in a readable word.
// - The program execution time is readable while a program runs.
//
// Operation in brief:
// The watchdog timer counts whole milliseconds from the last kick, where a kick is a scan start
// or an idle instruction taken from a ladder program. A tick that finds the count already at the
// limit trips the block: the reset request then stands for a fixed number of cycles and the
// error flag stays up until the system reset clears it.
// The scan timer runs on a millisecond of its own that restarts only at a scan start. Idle
// kicks therefore shorten neither the reported execution time nor the longest scan time.
// Both time words saturate at their top value instead of wrapping.
// The block never resets itself; the system is expected to feed the reset request back.
`timescale 1ns/1ps
module scw_watchdog import scw_pkg::*; #(
	parameter int unsigned TICK_CYC = TICK_CYCLES,
	parameter int unsigned RST_CYC = SYS_RESET_CYCLES
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire scw_prog_type prog,
	input wire logic timeout_valid,
	input wire logic [12:0] timeout_ms,
	output scw_times_type times,
	output logic wdt_error,
	output logic wdt_sys_reset,
	output logic [12:0] timeout_in_use
);
	localparam logic [12:0] TMIN = 13'(TIMEOUT_MIN_MS);
	localparam logic [12:0] TMAX = 13'(TIMEOUT_MAX_MS);
	localparam int RW = $clog2(RST_CYC + 1);
	localparam logic [RW-1:0] RST_LAST = RW'(RST_CYC);

	initial begin
		if (RST_CYC < 1) $error("scw_watchdog needs a reset pulse of one cycle or more.");
		if (TICK_CYC < 2) $error("scw_watchdog needs at least two cycles per millisecond.");
	end

	scw_state_type state_reg;
	scw_state_type state_next;
	logic [12:0] limit_reg;
	logic [12:0] limit_next;
	logic [12:0] wdt_ms_reg;
	logic [12:0] wdt_ms_next;
	logic [15:0] scan_ms_reg;
	logic [15:0] scan_ms_next;
	logic [15:0] max_reg;
	logic [15:0] max_next;
	logic [15:0] exec_reg;
	logic [15:0] exec_next;
	logic [RW-1:0] rst_cnt_reg;
	logic [RW-1:0] rst_cnt_next;
	logic err_reg;
	logic err_next;
	logic kick;
	logic tick;
	logic scan_tick;

	// A kick restarts timing; only ladder programs may kick by idle instruction.
	assign kick = prog.scan_start
		|| (prog.idle_instruction && prog.lang == SCW_LANG_LADDER);

	// The watchdog millisecond restarts on every kick.
	scw_tick #(
		.CYCLES(TICK_CYC)
	) u_tick (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clear(kick || state_reg != SCW_ST_RUNNING),
		.tick(tick)
	);

	// The scan millisecond restarts only at a scan start, so idle kicks do not shorten scans.
	scw_tick #(
		.CYCLES(TICK_CYC)
	) u_scan_tick (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.clear(prog.scan_start || state_reg != SCW_ST_RUNNING),
		.tick(scan_tick)
	);

	// Next limit; out-of-range settings are ignored so the limit stays sane.
	always_comb begin
		limit_next = limit_reg;
		if (timeout_valid && timeout_ms >= TMIN && timeout_ms <= TMAX) begin
			limit_next = timeout_ms;
		end
	end

	// Registers the timeout limit.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			limit_reg <= TIMEOUT_DEFAULT_MS;
		end else begin
			limit_reg <= limit_next;
		end
	end

	// Next values of the watchdog state, timer, pulse counter and error flag.
	always_comb begin
		state_next = state_reg;
		wdt_ms_next = wdt_ms_reg;
		rst_cnt_next = rst_cnt_reg;
		err_next = err_reg;
		case (state_reg)
			SCW_ST_STOPPED: begin
				wdt_ms_next = '0;
				if (prog.running) begin
					state_next = SCW_ST_RUNNING;
				end
			end
			SCW_ST_RUNNING: begin
				if (!prog.running) begin
					state_next = SCW_ST_STOPPED;
				end else if (kick) begin
					wdt_ms_next = '0;
				end else if (tick) begin
					// Tripping on a tick at the limit means the scan has outlived it.
					if (wdt_ms_reg >= limit_reg) begin
						state_next = SCW_ST_TRIPPED;
						err_next = 1'b1;
						rst_cnt_next = '0;
					end else begin
						wdt_ms_next = wdt_ms_reg + 1'b1;
					end
				end
			end
			SCW_ST_TRIPPED: begin
				// The pulse lasts a fixed count; the error flag survives until sys_rst.
				if (rst_cnt_reg == RST_LAST) begin
					state_next = SCW_ST_STOPPED;
				end else begin
					rst_cnt_next = rst_cnt_reg + 1'b1;
				end
			end
			default: begin
				state_next = SCW_ST_STOPPED;
			end
		endcase
	end

	// Registers the watchdog state group.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= SCW_ST_STOPPED;
			wdt_ms_reg <= '0;
			rst_cnt_reg <= '0;
			err_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			wdt_ms_reg <= wdt_ms_next;
			rst_cnt_reg <= rst_cnt_next;
			err_reg <= err_next;
		end
	end

	// Next values of the scan timer and the readable time words.
	always_comb begin
		scan_ms_next = scan_ms_reg;
		max_next = max_reg;
		exec_next = exec_reg;
		if (state_reg != SCW_ST_RUNNING) begin
			scan_ms_next = '0;
		end else if (prog.running && prog.scan_start) begin
			// The finished scan is reported and compared with the longest one.
			exec_next = scan_ms_reg;
			if (scan_ms_reg > max_reg) begin
				max_next = scan_ms_reg;
			end
			scan_ms_next = '0;
		end else if (scan_tick && scan_ms_reg != 16'hffff) begin
			// Scan time saturates rather than wrapping.
			scan_ms_next = scan_ms_reg + 1'b1;
		end
	end

	// Registers the scan timer and the time words.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			scan_ms_reg <= TIME_WORD_RESET;
			max_reg <= TIME_WORD_RESET;
			exec_reg <= TIME_WORD_RESET;
		end else begin
			scan_ms_reg <= scan_ms_next;
			max_reg <= max_next;
			exec_reg <= exec_next;
		end
	end

	// Outputs all come straight from registers or the state register.
	assign times.max_scan_time_word = max_reg;
	assign times.exec_time_word = exec_reg;
	assign wdt_error = err_reg;
	assign wdt_sys_reset = (state_reg == SCW_ST_TRIPPED);
	assign timeout_in_use = limit_reg;

endmodule : scw_watchdog

// ### verif/scw_watchdog_monitor.sv
// Port checker for the scan cycle watchdog.
`timescale 1ns/1ps
module scw_watchdog_monitor import scw_pkg::*; (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire scw_prog_type prog,
	input wire logic timeout_valid,
	input wire logic [12:0] timeout_ms,
	input wire scw_times_type times,
	input wire logic wdt_error,
	input wire logic wdt_sys_reset,
	input wire logic [12:0] timeout_in_use
);
	// All checks run on the core clock and sleep through reset.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic ok_ms;
	assign ok_ms = timeout_ms >= 13'h0064 && timeout_ms <= 13'h1388;
	sequence s_trip; $rose(wdt_sys_reset); endsequence
	// The pulse length assumes the bench sets RST_CYC to 4.
	sequence s_pulse; wdt_sys_reset[*5] ##1 !wdt_sys_reset; endsequence
	a_error_sticky: assert property (wdt_error |=> wdt_error)
		else $error("error flag dropped");
	a_trip_flags: assert property (s_trip |-> $rose(wdt_error))
		else $error("reset without error");
	a_pulse_len: assert property (s_trip |-> s_pulse)
		else $error("bad reset pulse");
	a_limit_load: assert property (timeout_valid && ok_ms && !wdt_error
		|=> timeout_in_use == $past(timeout_ms))
		else $error("limit not loaded");
	a_limit_hold: assert property (!(timeout_valid && ok_ms) |=> $stable(timeout_in_use))
		else $error("limit changed");
	a_kick_holds: assert property (prog.running && prog.idle_instruction
		&& prog.lang == SCW_LANG_LADDER |=> !wdt_sys_reset[*8])
		else $error("trip after kick");
	a_scan_restart: assert property (prog.running && prog.scan_start
		|=> !$rose(wdt_error) throughout 1'b1[*8])
		else $error("trip after scan start");
	a_max_rises: assert property (1'b1 |=> times.max_scan_time_word
		>= $past(times.max_scan_time_word))
		else $error("max word fell");
	a_exec_on_scan: assert property (!$past(prog.scan_start) && !$past(sys_rst)
		|-> $stable(times.exec_time_word))
		else $error("exec word moved");
endmodule : scw_watchdog_monitor

// ### verif/tb_scan_cycle_watchdog.sv
// Self-checking bench for the scan cycle watchdog.
`timescale 1ns/1ps
module tb_scan_cycle_watchdog import scw_pkg::*;;
	logic core_clk, sys_rst, timeout_valid, wdt_error, wdt_sys_reset;
	logic [12:0] timeout_ms, timeout_in_use;
	scw_prog_type prog;
	scw_times_type times;
	int fail_count, checks, n;
	// Timeout rows: requested value beside the limit it should leave.
	logic [12:0] row_in [5] = '{13'h0063, 13'h0064, 13'h1388, 13'h1389, 13'h0064};
	logic [12:0] row_out [5] = '{13'h0190, 13'h0064, 13'h1388, 13'h1388, 13'h0064};
	// Ten cycles per millisecond keeps each 100 ms scan near a thousand cycles.
	scw_watchdog #(.TICK_CYC(10), .RST_CYC(4)) i_scw_watchdog (.core_clk(core_clk),
		.sys_rst(sys_rst), .prog(prog), .timeout_valid(timeout_valid),
		.timeout_ms(timeout_ms), .times(times), .wdt_error(wdt_error),
		.wdt_sys_reset(wdt_sys_reset), .timeout_in_use(timeout_in_use));
	// Free-running 40 MHz core clock.
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Inputs move 1 ns after the rising edge.
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("fail_count=%0d checks=%0d", fail_count, checks);
		if (fail_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test
	// Main sequence.
	initial begin
		sys_rst = 1'b1;
		prog = '0;
		timeout_valid = 1'b0;
		timeout_ms = '0;
		cyc(2);
		sys_rst = 1'b0;
		check(timeout_in_use, 16'h0190);
		check(times.max_scan_time_word, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			timeout_ms = row_in[i];
			timeout_valid = 1'b1;
			cyc(1);
			timeout_valid = 1'b0;
			cyc(1);
			check(timeout_in_use, row_out[i]);
		end
		prog.running = 1'b1;
		cyc(1);
		// Four 80 ms scans, then four 80 ms ladder idle gaps, survive a 100 ms limit only if each scan start and idle instruction restarts timing.
		for (int i = 0; i < 8; i++) begin
			prog.scan_start = i < 4;
			prog.idle_instruction = i >= 4;
			cyc(1);
			prog.scan_start = 1'b0;
			prog.idle_instruction = 1'b0;
			cyc(799);
		end
		check(wdt_error, 16'h0000);
		check(times.exec_time_word inside {[79:80]}, 16'h0001);
		// Idle pulses in a diagram program must not hold off the trip.
		prog.lang = SCW_LANG_FBD;
		n = 0;
		while (wdt_error !== 1'b1 && n < 1100) begin
			prog.scan_start = n == 0;
			prog.idle_instruction = n % 500 == 1;
			cyc(1);
			n++;
		end
		check(n inside {[1005:1020]}, 16'h0001);
		check(times.max_scan_time_word inside {[399:400]}, 16'h0001);
		check(wdt_sys_reset, 16'h0001);
		cyc(5);
		check({wdt_sys_reset, wdt_error}, 16'h0001);
		sys_rst = 1'b1;
		cyc(1);
		sys_rst = 1'b0;
		check(wdt_error, 16'h0000);
		stop_test();
	end
endmodule : tb_scan_cycle_watchdog
bind scw_watchdog scw_watchdog_monitor i_scw_watchdog_monitor (.core_clk(core_clk),
	.sys_rst(sys_rst), .prog(prog), .timeout_valid(timeout_valid), .timeout_ms(timeout_ms),
	.times(times), .wdt_error(wdt_error), .wdt_sys_reset(wdt_sys_reset),
	.timeout_in_use(timeout_in_use));
